/* File: inc/task_file_pkg.sv */
// Constants and types for the task-file register port
package task_file_pkg;
   // Register selects produced by the address decoder
   typedef enum logic [3:0] {
      SEL_NONE = 4'h0,
      SEL_DATA = 4'h1,
      SEL_ERR_FEAT = 4'h2,
      SEL_SECT_CNT = 4'h3,
      SEL_LBA_LOW = 4'h4,
      SEL_LBA_MID = 4'h5,
      SEL_LBA_HIGH = 4'h6,
      SEL_DEV_HEAD = 4'h7,
      SEL_STAT_CMD = 4'h8,
      SEL_ALT_CTRL = 4'h9,
      SEL_DRV_ADDR = 4'ha
   } reg_sel_t;

   // Command-block offsets (first chip select)
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_ERR_FEAT = 3'h1;
   localparam logic [2:0] OFS_SECT_CNT = 3'h2;
   localparam logic [2:0] OFS_LBA_LOW = 3'h3;
   localparam logic [2:0] OFS_LBA_MID = 3'h4;
   localparam logic [2:0] OFS_LBA_HIGH = 3'h5;
   localparam logic [2:0] OFS_DEV_HEAD = 3'h6;
   localparam logic [2:0] OFS_STAT_CMD = 3'h7;
   // Control-block offsets (second chip select)
   localparam logic [2:0] OFS_ALT_CTRL = 3'h6;
   localparam logic [2:0] OFS_DRV_ADDR = 3'h7;

   // Device control fields
   localparam int CTL_HOB = 7;
   localparam int CTL_SOFT_RESET_BIT = 2;
   localparam int CTL_IEN_N = 1;
   // Device/head fields
   localparam int DEV_FIX7 = 7;
   localparam int DEV_LBA_MODE = 6;
   localparam int DEV_FIX5 = 5;
   localparam int DEV_DRV = 4;
   // Drive address fields
   localparam int DA_FLOAT = 7;
   localparam int DA_WTG_N = 6;

   // Reset values and read-enable masks
   localparam logic [7:0] DEV_HEAD_RST = 8'ha0;
   localparam logic [7:0] CTL_RST = 8'h08;
   localparam logic [7:0] DIAG_POR = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] OE_WORD = 16'hffff;
   localparam logic [15:0] OE_BYTE = 16'h00ff;
   localparam logic [15:0] OE_DRV_ADDR = 16'h007f;

   // Least soft-reset hold expected from the host
   localparam int SOFT_RESET_BIT_HOLD_MS = 5;
   localparam int CLK_HZ = 10_000_000;
   localparam longint SOFT_RESET_BIT_HOLD_CYC = longint'(SOFT_RESET_BIT_HOLD_MS) * CLK_HZ / 1000;

   // Width of the synchronised pin bundle
   localparam int PIN_W = 24;
endpackage : task_file_pkg

/* File: rtl/task_file_port.sv */
// Device-side task-file register port of a parallel disk interface
`timescale 1ns/1ps

// Function
// - First select decodes eight command-block registers
// - Second select: alt status/control, drive address
// - Unmapped reads float bus, writes ignored
// - Alt status mirrors status, no acknowledge
// - Command write starts execution at once
// - Data words 16 bits, ECC bytes 8
// - Data valid only while data request set
// - Command-block write clears high-order-byte flag
// - Soft-reset bit holds device in reset
// - Interrupt only when enabled and selected
// - Drive address inverted; bit 7 floats
// - Write-gate bit low while writing disk
// - Bits 5..2 inverted current head number
// - Bits 1,0 active-low drive selects
// - Device bits 7,5 one; bit 6 mode
// - Device bit 4 selects master/slave
// - Device nibble updated at command completion
// - Error register flag layout, bits 5,3 zero
// - Error register valid after normal completion
// - Diagnostic code after reset or diagnostic
// - Abort flag on abort, device fault or bad parameter
// - Status read acknowledges pending interrupt
// - While busy every mapped read returns status
module task_file_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host pins
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic diow_n,
   input wire logic [15:0] dd_in,
   output logic [15:0] dd_out,
   output logic [15:0] dd_oe,
   output logic intrq,
   // Strap: this drive answers as device 1
   input wire logic is_slave,
   // Status from the drive core
   input wire logic busy_flag,
   input wire logic device_ready_flag,
   input wire logic device_fault_flag,
   input wire logic seek_complete_flag,
   input wire logic data_request_flag,
   input wire logic index_pulse_flag,
   input wire logic error_flag,
   // Command completion from the drive core
   input wire logic cmd_done,
   input wire logic diag_done,
   input wire logic [7:0] diag_code,
   input wire logic [3:0] lba_upper_now,
   input wire logic interface_crc_error_flag,
   input wire logic uncorrectable_flag,
   input wire logic sector_id_missing_flag,
   input wire logic aborted_flag,
   input wire logic invalid_param,
   input wire logic track_zero_missing_flag,
   input wire logic address_mark_missing_flag,
   input wire logic irq_event,
   // Drive mechanics
   input wire logic [3:0] head_num,
   input wire logic disk_writing,
   // Data path to the sector buffer
   input wire logic ecc_byte_mode,
   input wire logic [15:0] buf_rd_word,
   output logic buf_rd_pop,
   output logic buf_wr_push,
   output logic [15:0] buf_wr_word,
   // Command and parameters to the drive core
   output logic command_start,
   output logic [7:0] command_code,
   output logic [7:0] feature_parameter,
   output logic [7:0] sector_count,
   output logic [7:0] lba_low,
   output logic [7:0] lba_mid,
   output logic [7:0] lba_high,
   output logic [7:0] device_head_select,
   output logic soft_reset_bit,
   output logic high_order_byte_flag
);

   // Address decode shared by the read and write paths
   function automatic task_file_pkg::reg_sel_t decode(
      input logic c0_n, input logic c1_n, input logic [2:0] a);
      task_file_pkg::reg_sel_t s;
      s = task_file_pkg::SEL_NONE;
      if (!c0_n && c1_n) begin
         case (a)
            task_file_pkg::OFS_DATA: s = task_file_pkg::SEL_DATA;
            task_file_pkg::OFS_ERR_FEAT: s = task_file_pkg::SEL_ERR_FEAT;
            task_file_pkg::OFS_SECT_CNT: s = task_file_pkg::SEL_SECT_CNT;
            task_file_pkg::OFS_LBA_LOW: s = task_file_pkg::SEL_LBA_LOW;
            task_file_pkg::OFS_LBA_MID: s = task_file_pkg::SEL_LBA_MID;
            task_file_pkg::OFS_LBA_HIGH: s = task_file_pkg::SEL_LBA_HIGH;
            task_file_pkg::OFS_DEV_HEAD: s = task_file_pkg::SEL_DEV_HEAD;
            default: s = task_file_pkg::SEL_STAT_CMD;
         endcase
      end else if (c0_n && !c1_n && a == task_file_pkg::OFS_ALT_CTRL) begin
         s = task_file_pkg::SEL_ALT_CTRL;
      end else if (c0_n && !c1_n && a == task_file_pkg::OFS_DRV_ADDR) begin
         s = task_file_pkg::SEL_DRV_ADDR;
      end else begin
         s = task_file_pkg::SEL_NONE;
      end
      return s;
   endfunction : decode

   // Pin synchroniser state
   logic [task_file_pkg::PIN_W-1:0] meta_q, meta_d;
   logic [task_file_pkg::PIN_W-1:0] pins_q, pins_d;
   logic [task_file_pkg::PIN_W-1:0] prev_q, prev_d;

   // Synchronised views of the pins
   logic s_cs0_n, s_cs1_n, s_rd_n, s_wr_n, s_slave, p_rd_n, p_wr_n;
   logic [2:0] s_da;
   logic [15:0] s_dd;
   task_file_pkg::reg_sel_t sel;
   logic wr_rel, rd_start, reading;

   // Task-file state
   logic [7:0] cmd_q, cmd_d, feat_q, feat_d, scnt_q, scnt_d;
   logic [7:0] llo_q, llo_d, lmid_q, lmid_d, lhi_q, lhi_d;
   logic [7:0] dev_q, dev_d, ctl_q, ctl_d, err_q, err_d;
   logic start_q, start_d, push_q, push_d, pop_q, pop_d;
   logic [15:0] wword_q, wword_d;
   logic pend_q, pend_d, soft_reset_bit_prev_q, soft_reset_bit_prev_d;

   // Read path state
   logic [15:0] dout_q, dout_d, doe_q, doe_d;
   logic irq_q, irq_d;

   // Combinational helpers
   logic [7:0] status_byte, drv_addr_byte;
   logic selected;

   // Pins pass two flops before use; the third stage gives edge history
   always_comb begin
      meta_d = {cs0_n, cs1_n, da, dior_n, diow_n, dd_in, is_slave};
      pins_d = meta_q;
      prev_d = pins_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= {2'b11, 3'h0, 2'b11, 16'h0000, 1'b0};
         pins_q <= {2'b11, 3'h0, 2'b11, 16'h0000, 1'b0};
         prev_q <= {2'b11, 3'h0, 2'b11, 16'h0000, 1'b0};
      end else begin
         meta_q <= meta_d;
         pins_q <= pins_d;
         prev_q <= prev_d;
      end
   end

   // Unpack the synchronised bundle and find strobe edges
   assign s_cs0_n = pins_q[23];
   assign s_cs1_n = pins_q[22];
   assign s_da = pins_q[21:19];
   assign s_rd_n = pins_q[18];
   assign s_wr_n = pins_q[17];
   assign s_dd = pins_q[16:1];
   assign s_slave = pins_q[0];
   assign p_rd_n = prev_q[18];
   assign p_wr_n = prev_q[17];
   assign sel = decode(s_cs0_n, s_cs1_n, s_da);
   assign wr_rel = s_wr_n && !p_wr_n;
   assign rd_start = !s_rd_n && p_rd_n;
   assign reading = !s_rd_n;

   // Status byte shared by status, alternate status and busy reads
   assign status_byte = {busy_flag, device_ready_flag, device_fault_flag,
                         seek_complete_flag, data_request_flag, 1'b0,
                         index_pulse_flag, error_flag};

   // This drive is the one named by the device register
   assign selected = (dev_q[task_file_pkg::DEV_DRV] == s_slave);

   // Drive address readback, bits 6..0 inverted; bit 7 floats
   always_comb begin
      drv_addr_byte = 8'hff;
      drv_addr_byte[task_file_pkg::DA_FLOAT] = 1'b0;
      drv_addr_byte[task_file_pkg::DA_WTG_N] = !disk_writing;
      drv_addr_byte[5:2] = ~head_num;
      drv_addr_byte[1] = !(selected && s_slave);
      drv_addr_byte[0] = !(selected && !s_slave);
   end

   // Register writes, command start and side effects
   always_comb begin
      cmd_d = cmd_q;
      feat_d = feat_q;
      scnt_d = scnt_q;
      llo_d = llo_q;
      lmid_d = lmid_q;
      lhi_d = lhi_q;
      dev_d = dev_q;
      ctl_d = ctl_q;
      err_d = err_q;
      start_d = 1'b0;
      push_d = 1'b0;
      pop_d = 1'b0;
      wword_d = wword_q;
      pend_d = pend_q;
      soft_reset_bit_prev_d = ctl_q[task_file_pkg::CTL_SOFT_RESET_BIT];
      if (wr_rel) begin
         if (sel != task_file_pkg::SEL_NONE && sel != task_file_pkg::SEL_ALT_CTRL
             && sel != task_file_pkg::SEL_DRV_ADDR) begin
            ctl_d[task_file_pkg::CTL_HOB] = 1'b0;
         end
         case (sel)
            task_file_pkg::SEL_DATA: begin
               push_d = 1'b1;
               wword_d = ecc_byte_mode ? {8'h00, s_dd[7:0]} : s_dd;
            end
            task_file_pkg::SEL_ERR_FEAT: feat_d = s_dd[7:0];
            task_file_pkg::SEL_SECT_CNT: scnt_d = s_dd[7:0];
            task_file_pkg::SEL_LBA_LOW: llo_d = s_dd[7:0];
            task_file_pkg::SEL_LBA_MID: lmid_d = s_dd[7:0];
            task_file_pkg::SEL_LBA_HIGH: lhi_d = s_dd[7:0];
            task_file_pkg::SEL_DEV_HEAD: dev_d = s_dd[7:0];
            task_file_pkg::SEL_STAT_CMD: begin
               cmd_d = s_dd[7:0];
               start_d = 1'b1;
            end
            task_file_pkg::SEL_ALT_CTRL: begin
               ctl_d = s_dd[7:0];
               ctl_d[3] = 1'b1;
               ctl_d[0] = 1'b0;
            end
            default: ctl_d = ctl_d;
         endcase
      end
      // Fixed device register bits
      dev_d[task_file_pkg::DEV_FIX7] = 1'b1;
      dev_d[task_file_pkg::DEV_FIX5] = 1'b1;
      // Completion updates and error capture
      if (cmd_done) begin
         dev_d[3:0] = lba_upper_now;
         err_d = {interface_crc_error_flag, uncorrectable_flag, 1'b0,
                  sector_id_missing_flag, 1'b0,
                  aborted_flag || invalid_param || device_fault_flag,
                  track_zero_missing_flag, address_mark_missing_flag};
      end
      if (diag_done) begin
         err_d = diag_code;
      end
      // Soft reset release reloads the diagnostic code
      if (soft_reset_bit_prev_q && !ctl_q[task_file_pkg::CTL_SOFT_RESET_BIT]) begin
         err_d = diag_code;
      end
      // Data word popped when the host takes a valid word
      if (rd_start && sel == task_file_pkg::SEL_DATA && !busy_flag && data_request_flag) begin
         pop_d = 1'b1;
      end
      // Pending interrupt: a new event wins over the acknowledge
      if (rd_start && sel == task_file_pkg::SEL_STAT_CMD) begin
         pend_d = 1'b0;
      end
      if (ctl_q[task_file_pkg::CTL_SOFT_RESET_BIT]) begin
         pend_d = 1'b0;
      end
      if (irq_event && !ctl_q[task_file_pkg::CTL_SOFT_RESET_BIT]) begin
         pend_d = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_q <= task_file_pkg::BYTE_ZERO;
         feat_q <= task_file_pkg::BYTE_ZERO;
         scnt_q <= task_file_pkg::BYTE_ZERO;
         llo_q <= task_file_pkg::BYTE_ZERO;
         lmid_q <= task_file_pkg::BYTE_ZERO;
         lhi_q <= task_file_pkg::BYTE_ZERO;
         dev_q <= task_file_pkg::DEV_HEAD_RST;
         ctl_q <= task_file_pkg::CTL_RST;
         err_q <= task_file_pkg::DIAG_POR;
         start_q <= 1'b0;
         push_q <= 1'b0;
         pop_q <= 1'b0;
         wword_q <= task_file_pkg::WORD_ZERO;
         pend_q <= 1'b0;
         soft_reset_bit_prev_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         feat_q <= feat_d;
         scnt_q <= scnt_d;
         llo_q <= llo_d;
         lmid_q <= lmid_d;
         lhi_q <= lhi_d;
         dev_q <= dev_d;
         ctl_q <= ctl_d;
         err_q <= err_d;
         start_q <= start_d;
         push_q <= push_d;
         pop_q <= pop_d;
         wword_q <= wword_d;
         pend_q <= pend_d;
         soft_reset_bit_prev_q <= soft_reset_bit_prev_d;
      end
   end

   // Read data mux; the bus is driven only while the synchronised read strobe is low
   always_comb begin
      dout_d = task_file_pkg::WORD_ZERO;
      doe_d = task_file_pkg::WORD_ZERO;
      if (reading && sel != task_file_pkg::SEL_NONE) begin
         doe_d = task_file_pkg::OE_BYTE;
         if (busy_flag) begin
            dout_d = {8'h00, status_byte};
         end else begin
            case (sel)
               task_file_pkg::SEL_DATA: begin
                  doe_d = ecc_byte_mode ? task_file_pkg::OE_BYTE
                                        : task_file_pkg::OE_WORD;
                  if (data_request_flag) begin
                     dout_d = ecc_byte_mode ? {8'h00, buf_rd_word[7:0]}
                                            : buf_rd_word;
                  end
               end
               task_file_pkg::SEL_ERR_FEAT: dout_d = {8'h00, err_q};
               task_file_pkg::SEL_SECT_CNT: dout_d = {8'h00, scnt_q};
               task_file_pkg::SEL_LBA_LOW: dout_d = {8'h00, llo_q};
               task_file_pkg::SEL_LBA_MID: dout_d = {8'h00, lmid_q};
               task_file_pkg::SEL_LBA_HIGH: dout_d = {8'h00, lhi_q};
               task_file_pkg::SEL_DEV_HEAD: dout_d = {8'h00, dev_q};
               task_file_pkg::SEL_DRV_ADDR: begin
                  dout_d = {8'h00, drv_addr_byte};
                  doe_d = task_file_pkg::OE_DRV_ADDR;
               end
               default: dout_d = {8'h00, status_byte};
            endcase
         end
      end
      // Interrupt line gated by enable and selection
      irq_d = pend_q && !ctl_q[task_file_pkg::CTL_IEN_N] && selected;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout_q <= task_file_pkg::WORD_ZERO;
         doe_q <= task_file_pkg::WORD_ZERO;
         irq_q <= 1'b0;
      end else begin
         dout_q <= dout_d;
         doe_q <= doe_d;
         irq_q <= irq_d;
      end
   end

   // Outputs
   assign dd_out = dout_q;
   assign dd_oe = doe_q;
   assign intrq = irq_q;
   assign buf_rd_pop = pop_q;
   assign buf_wr_push = push_q;
   assign buf_wr_word = wword_q;
   assign command_start = start_q;
   assign command_code = cmd_q;
   assign feature_parameter = feat_q;
   assign sector_count = scnt_q;
   assign lba_low = llo_q;
   assign lba_mid = lmid_q;
   assign lba_high = lhi_q;
   assign device_head_select = dev_q;
   assign soft_reset_bit = ctl_q[task_file_pkg::CTL_SOFT_RESET_BIT];
   assign high_order_byte_flag = ctl_q[task_file_pkg::CTL_HOB];

endmodule : task_file_port

/* File: verification/task_file_port_asserts.sv */
// Concurrent checks on the task-file port pins
`timescale 1ns/1ps
module task_file_port_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host pins
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic [15:0] dd_out,
   input wire logic [15:0] dd_oe,
   input wire logic intrq,
   // Core status and mechanics
   input wire logic busy_flag,
   input wire logic device_ready_flag,
   input wire logic device_fault_flag,
   input wire logic seek_complete_flag,
   input wire logic data_request_flag,
   input wire logic index_pulse_flag,
   input wire logic error_flag,
   input wire logic [3:0] head_num,
   input wire logic disk_writing,
   // Outputs toward the core
   input wire logic command_start,
   input wire logic buf_wr_push,
   input wire logic [7:0] device_head_select,
   input wire logic soft_reset_bit,
   input wire logic high_order_byte_flag
);
   logic [7:0] stat;
   logic cmd_sel;
   logic ctl_rd;
   // Status byte as the host sees it, corrected bit always 0
   assign stat = {busy_flag, device_ready_flag, device_fault_flag, seek_complete_flag,
      data_request_flag, 1'b0, index_pulse_flag, error_flag};
   // Select decodes shared by several checks
   assign cmd_sel = !cs0_n && cs1_n && da == task_file_pkg::OFS_STAT_CMD;
   assign ctl_rd = !dior_n && cs0_n && !cs1_n;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_idle_float; dior_n [*5] |-> dd_oe == 16'h0000; endproperty
   a_idle_float: assert property (p_idle_float) else $error("bus driven with no read");
   property p_sel_bad; (cs0_n == cs1_n) [*5] |-> dd_oe == 16'h0000; endproperty
   a_sel_bad: assert property (p_sel_bad) else $error("bus driven on bad select");
   property p_ctl_gap; (cs0_n && !cs1_n && da < 3'h6) [*5] |-> dd_oe == 16'h0000; endproperty
   a_ctl_gap: assert property (p_ctl_gap) else $error("bus driven on unmapped place");
   property p_alt; (ctl_rd && da == 3'h6 && $stable(stat)) [*5]
      |-> dd_out[7:0] == stat && dd_oe == task_file_pkg::OE_BYTE; endproperty
   a_alt: assert property (p_alt) else $error("alternate status wrong");
   property p_alt_keep; intrq && ctl_rd && da == 3'h6 && !soft_reset_bit |=> intrq; endproperty
   a_alt_keep: assert property (p_alt_keep) else $error("alternate read cleared irq");
   property p_busy; (!dior_n && !cs0_n && cs1_n && busy_flag && $stable(stat) && $stable(da))
      [*5] |-> dd_out[7:0] == stat; endproperty
   a_busy: assert property (p_busy) else $error("busy read not status");
   property p_drv; (ctl_rd && da == 3'h7 && !busy_flag && $stable(head_num)
      && $stable(disk_writing)) [*5] |-> dd_oe == task_file_pkg::OE_DRV_ADDR
      && dd_out[6:2] == {!disk_writing, ~head_num}; endproperty
   a_drv: assert property (p_drv) else $error("drive address wrong");
   property p_dev_fix; device_head_select[7] && device_head_select[5]; endproperty
   a_dev_fix: assert property (p_dev_fix) else $error("device fixed bits wrong");
   property p_hob; command_start || buf_wr_push |-> !high_order_byte_flag; endproperty
   a_hob: assert property (p_hob) else $error("order flag not cleared");
   property p_cmd; command_start |-> $past(cmd_sel, 4); endproperty
   a_cmd: assert property (p_cmd) else $error("start without command write");
   property p_soft_reset_bit; soft_reset_bit [*3] |-> !intrq; endproperty
   a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("irq while in soft reset");

   // Main scenarios reached
   c_cmd: cover property (command_start);
   c_push: cover property (buf_wr_push);
   c_irq: cover property ($rose(intrq));
   c_drv: cover property (dd_oe == task_file_pkg::OE_DRV_ADDR);
endmodule : task_file_port_asserts

bind task_file_port task_file_port_asserts i_chk (.*);

/* File: verification/host_model.sv */
// Host controller model that drives the task-file pins
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk,
   // Pins toward the device
   output logic cs0_n,
   output logic cs1_n,
   output logic [2:0] da,
   output logic dior_n,
   output logic diow_n,
   output logic [15:0] dd_in,
   input wire logic [15:0] dd_out,
   input wire logic [15:0] dd_oe
);
   // Idle bus: nothing selected, strobes high
   initial begin
      cs0_n = 1'b1;
      cs1_n = 1'b1;
      da = 3'h0;
      dior_n = 1'b1;
      diow_n = 1'b1;
      dd_in = 16'h0000;
   end

   // One strobe cycle, pins changed at the falling clock edge
   task automatic access(input logic wr, input logic [1:0] sel, input logic [2:0] a,
         input logic [15:0] d, output logic [15:0] q, output logic [15:0] oe);
      @(negedge clk);
      cs0_n = ~sel[0];  // Both selects only when a test asks for it
      cs1_n = ~sel[1];
      da = a;
      dd_in = wr ? d : ~dd_in;  // Full word on every write
      dior_n = wr;
      diow_n = ~wr;
      repeat (5) @(negedge clk);
      q = dd_out;
      oe = dd_oe;
      dior_n = 1'b1;
      diow_n = 1'b1;
      repeat (8) @(negedge clk);  // Hold select and data past the taking edge
      cs0_n = 1'b1;
      cs1_n = 1'b1;
      dd_in = ~dd_in;  // Released lines lose the last value
   endtask : access
endmodule : host_model

/* File: verification/disk_task_file_register_port_test.sv */
// Self-checking testbench for the task-file register port
`timescale 1ns/1ps
module disk_task_file_register_port_test;
   localparam logic [1:0] CMD = 2'b01;
   localparam logic [1:0] CTL = 2'b10;
   logic clk, rst, is_slave, disk_writing, ecc_byte_mode;
   logic [7:0] st, diag_code;
   logic [6:0] ef;
   logic [2:0] ev;
   logic [3:0] head_num, lba_upper_now;
   logic [15:0] buf_rd_word, q, oe;
   wire cs0_n, cs1_n, dior_n, diow_n, intrq, command_start, buf_wr_push;
   wire soft_reset_bit, high_order_byte_flag, buf_rd_pop;
   wire [2:0] da;
   wire [15:0] dd_in, dd_out, dd_oe, buf_wr_word;
   wire [7:0] command_code, feature_parameter, lba_low, device_head_select;
   wire [7:0] sector_count, lba_mid, lba_high;
   int n_fail = 0;
   int checked = 0;
   int n_start = 0;
   int n_pop = 0;
   int n_push = 0;

   task_file_port i_dut (
      .clk(clk), .rst(rst), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
      .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe), .intrq(intrq),
      .is_slave(is_slave), .busy_flag(st[7]), .device_ready_flag(st[6]),
      .device_fault_flag(st[5]), .seek_complete_flag(st[4]), .data_request_flag(st[3]),
      .index_pulse_flag(st[1]), .error_flag(st[0]), .cmd_done(ev[1]), .diag_done(ev[2]),
      .diag_code(diag_code), .lba_upper_now(lba_upper_now),
      .interface_crc_error_flag(ef[6]), .uncorrectable_flag(ef[5]),
      .sector_id_missing_flag(ef[4]), .aborted_flag(ef[3]), .invalid_param(ef[2]),
      .track_zero_missing_flag(ef[1]), .address_mark_missing_flag(ef[0]),
      .irq_event(ev[0]), .head_num(head_num), .disk_writing(disk_writing),
      .ecc_byte_mode(ecc_byte_mode), .buf_rd_word(buf_rd_word), .buf_rd_pop(buf_rd_pop),
      .buf_wr_push(buf_wr_push), .buf_wr_word(buf_wr_word), .command_start(command_start),
      .command_code(command_code), .feature_parameter(feature_parameter),
      .sector_count(sector_count), .lba_low(lba_low), .lba_mid(lba_mid), .lba_high(lba_high),
      .device_head_select(device_head_select), .soft_reset_bit(soft_reset_bit),
      .high_order_byte_flag(high_order_byte_flag));

   host_model i_host (.clk(clk), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
      .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Count command start, buffer pop and buffer push pulses
   always @(posedge clk) begin
      if (command_start === 1'b1) n_start++;
      if (buf_rd_pop === 1'b1) n_pop++;
      if (buf_wr_push === 1'b1) n_push++;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [1:0] sel, input logic [2:0] a, input logic [15:0] d);
      i_host.access(1'b1, sel, a, d, q, oe);
   endtask : wr

   task automatic rd(input logic [1:0] sel, input logic [2:0] a, input logic [15:0] e,
         input logic [15:0] eo);
      i_host.access(1'b0, sel, a, 16'h0000, q, oe);
      check("read data", q & eo, e);
      check("read enable", oe, eo);
   endtask : rd

   // One-cycle event pulse toward the port
   task automatic pulse(input logic [2:0] m);
      @(negedge clk);
      ev = m;
      @(negedge clk);
      ev = 3'h0;
      repeat (3) @(negedge clk);
   endtask : pulse

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // Watchdog against a hung run
   initial begin
      #7_000_000;
      n_fail++;
      end_of_test();
   end

   // Reset, then the scenarios in turn
   initial begin
      rst = 1'b1;
      {is_slave, disk_writing, ecc_byte_mode, ev, ef} = '0;
      st = 8'h50;
      head_num = 4'h5;
      lba_upper_now = 4'h0;
      diag_code = 8'h7e;
      buf_rd_word = 16'h0000;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      rd(CMD, 3'h6, {8'h00, task_file_pkg::DEV_HEAD_RST}, 16'h00ff);
      rd(CMD, 3'h1, {8'h00, task_file_pkg::DIAG_POR}, 16'h00ff);
      for (int i = 2; i < 6; i++) begin
         wr(CMD, 3'(i), 16'(i + 8'h30));
         rd(CMD, 3'(i), 16'(i + 8'h30), 16'h00ff);
      end
      check("count and mid", {sector_count, lba_mid}, 16'h3234);
      check("lba high", {8'h00, lba_high}, 16'h0035);
      wr(CMD, 3'h6, 16'h0045);
      rd(CMD, 3'h6, 16'h00e5, 16'h00ff);
      $display("test decode done");
      wr(CTL, 3'h6, 16'h0086);
      check("soft reset", {15'h0, soft_reset_bit}, 16'h0001);
      pulse(3'h1);
      check("irq", {15'h0, intrq}, 16'h0000);
      repeat (task_file_pkg::SOFT_RESET_BIT_HOLD_CYC) @(negedge clk);
      wr(CTL, 3'h6, 16'h0080);
      wr(CMD, 3'h3, 16'h0033);
      check("order flag", {15'h0, high_order_byte_flag}, 16'h0000);
      rd(CMD, 3'h1, {8'h00, diag_code}, 16'h00ff);
      rd(2'b00, 3'h3, 16'h0000, 16'h0000);
      for (int i = 0; i < 6; i++) rd(CTL, 3'(i), 16'h0000, 16'h0000);
      rd(2'b11, 3'h7, 16'h0000, 16'h0000);
      wr(2'b00, 3'h3, 16'h00aa);
      wr(2'b11, 3'h3, 16'h00bb);
      check("lba low", {8'h00, lba_low}, 16'h0033);
      $display("test control done");
      wr(CMD, 3'h1, 16'h0003);
      wr(CMD, 3'h7, 16'h00ec);
      check("starts", 16'(n_start), 16'h0001);
      check("command", {8'h00, command_code}, 16'h00ec);
      check("feature", {8'h00, feature_parameter}, 16'h0003);
      pulse(3'h1);
      check("irq", {15'h0, intrq}, 16'h0001);
      rd(CTL, 3'h6, {8'h00, st}, 16'h00ff);
      check("irq", {15'h0, intrq}, 16'h0001);
      rd(CMD, 3'h7, {8'h00, st}, 16'h00ff);
      check("irq", {15'h0, intrq}, 16'h0000);
      wr(CTL, 3'h6, 16'h000a);
      pulse(3'h1);
      check("irq", {15'h0, intrq}, 16'h0000);
      wr(CMD, 3'h6, 16'h00f0);
      wr(CTL, 3'h6, 16'h0008);
      check("irq", {15'h0, intrq}, 16'h0000);
      rd(CTL, 3'h7, 16'h006b, 16'h007f);
      wr(CMD, 3'h6, 16'h00e0);
      check("irq", {15'h0, intrq}, 16'h0001);
      disk_writing = 1'b1;
      rd(CTL, 3'h7, 16'h002a, 16'h007f);
      $display("test interrupt done");
      st = 8'hd0;
      rd(CMD, 3'h4, 16'h00d0, 16'h00ff);
      st = 8'h58;
      ef = 7'h55;
      lba_upper_now = 4'h9;
      pulse(3'h2);
      rd(CMD, 3'h1, 16'h0095, 16'h00ff);
      rd(CMD, 3'h6, 16'h00e9, 16'h00ff);
      ef = 7'h00;
      pulse(3'h2);
      rd(CMD, 3'h1, 16'h0000, 16'h00ff);
      pulse(3'h4);
      rd(CMD, 3'h1, {8'h00, diag_code}, 16'h00ff);
      $display("test completion done");
      buf_rd_word = 16'hbeef;
      rd(CMD, 3'h0, 16'hbeef, 16'hffff);
      ecc_byte_mode = 1'b1;
      rd(CMD, 3'h0, 16'h00ef, 16'h00ff);
      ecc_byte_mode = 1'b0;
      wr(CMD, 3'h0, 16'h1234);
      check("pushed word", buf_wr_word, 16'h1234);
      st = 8'h50;
      rd(CMD, 3'h0, 16'h0000, 16'hffff);
      check("pops", 16'(n_pop), 16'h0002);
      check("pushes", 16'(n_push), 16'h0001);
      $display("test data done");
      end_of_test();
   end
endmodule : disk_task_file_register_port_test
